// ===== pkg/rsc_defines.svh
// timing and width constants for the reset strap capture block
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

`define RSC_STRAP_W 8
`define RSC_STRAP_DEFAULT 8'h00
`define RSC_PULL_HOLD_CLKS 4
`define RSC_HOLD_CNT_W 3
`define RSC_HOLD_CNT_ZERO 3'h0
`define RSC_HOLD_CNT_ONE 3'h1

`endif

// ===== pkg/rsc_pkg.sv
// types for the reset strap capture block
package rsc_pkg;
  typedef enum logic [1:0] {
    RSC_IN_RESET,
    RSC_PULL_HOLD,
    RSC_RUN
  } rsc_state_t;

  typedef enum logic [3:0] {
    RSC_TAP_RESET,
    RSC_TAP_IDLE,
    RSC_TAP_SEL_DR,
    RSC_TAP_CAP_DR,
    RSC_TAP_SHIFT_DR,
    RSC_TAP_EXIT1_DR,
    RSC_TAP_PAUSE_DR,
    RSC_TAP_EXIT2_DR,
    RSC_TAP_UPD_DR,
    RSC_TAP_SEL_IR,
    RSC_TAP_CAP_IR,
    RSC_TAP_SHIFT_IR,
    RSC_TAP_EXIT1_IR,
    RSC_TAP_PAUSE_IR,
    RSC_TAP_EXIT2_IR,
    RSC_TAP_UPD_IR
  } rsc_tap_state_t;
endpackage

// ===== hw/rsc_tap_fsm.sv
// tap controller state tracking with test reset and tms-only reset
`timescale 1ns/1ns
`default_nettype none
module rsc_tap_fsm
  import rsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tck_en,
  input wire logic tms,
  input wire logic trst_n,
  output logic tap_in_reset
);
  rsc_tap_state_t state_q;
  rsc_tap_state_t state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      RSC_TAP_RESET: state_d = tms ? RSC_TAP_RESET : RSC_TAP_IDLE;
      RSC_TAP_IDLE: state_d = tms ? RSC_TAP_SEL_DR : RSC_TAP_IDLE;
      RSC_TAP_SEL_DR: state_d = tms ? RSC_TAP_SEL_IR : RSC_TAP_CAP_DR;
      RSC_TAP_CAP_DR: state_d = tms ? RSC_TAP_EXIT1_DR : RSC_TAP_SHIFT_DR;
      RSC_TAP_SHIFT_DR: state_d = tms ? RSC_TAP_EXIT1_DR : RSC_TAP_SHIFT_DR;
      RSC_TAP_EXIT1_DR: state_d = tms ? RSC_TAP_UPD_DR : RSC_TAP_PAUSE_DR;
      RSC_TAP_PAUSE_DR: state_d = tms ? RSC_TAP_EXIT2_DR : RSC_TAP_PAUSE_DR;
      RSC_TAP_EXIT2_DR: state_d = tms ? RSC_TAP_UPD_DR : RSC_TAP_SHIFT_DR;
      RSC_TAP_UPD_DR: state_d = tms ? RSC_TAP_SEL_DR : RSC_TAP_IDLE;
      RSC_TAP_SEL_IR: state_d = tms ? RSC_TAP_RESET : RSC_TAP_CAP_IR;
      RSC_TAP_CAP_IR: state_d = tms ? RSC_TAP_EXIT1_IR : RSC_TAP_SHIFT_IR;
      RSC_TAP_SHIFT_IR: state_d = tms ? RSC_TAP_EXIT1_IR : RSC_TAP_SHIFT_IR;
      RSC_TAP_EXIT1_IR: state_d = tms ? RSC_TAP_UPD_IR : RSC_TAP_PAUSE_IR;
      RSC_TAP_PAUSE_IR: state_d = tms ? RSC_TAP_EXIT2_IR : RSC_TAP_PAUSE_IR;
      RSC_TAP_EXIT2_IR: state_d = tms ? RSC_TAP_UPD_IR : RSC_TAP_SHIFT_IR;
      RSC_TAP_UPD_IR: state_d = tms ? RSC_TAP_SEL_DR : RSC_TAP_IDLE;
      default: state_d = RSC_TAP_RESET;
    endcase
  end

  // test reset forces the reset state; otherwise five tms-high ticks also reach it
  always_ff @(posedge clk) begin
    if (rst || !trst_n) begin
      state_q <= RSC_TAP_RESET;
    end else if (tck_en) begin
      state_q <= state_d;
    end
  end

  assign tap_in_reset = (state_q == RSC_TAP_RESET);

  a_tap_trst_reset: assert property (@(posedge clk) disable iff (rst)
    !trst_n |=> tap_in_reset) else $error("tap not reset by test reset");
  a_tap_tms_reset: assert property (@(posedge clk) disable iff (rst)
    (tck_en && tms) [*5] |-> ##1 tap_in_reset)
    else $error("tap not reset after five tms-high ticks");
endmodule
`default_nettype wire

// ===== hw/rsc_strap_capture.sv
// strap capture, strap pad control, soft reset to machine check, tap reset
`timescale 1ns/1ns
`default_nettype none
`include "rsc_defines.svh"
module rsc_strap_capture
  import rsc_pkg::*;
#(
  parameter int STRAP_W = `RSC_STRAP_W,
  parameter int PULL_HOLD_CLKS = `RSC_PULL_HOLD_CLKS,
  parameter logic [`RSC_STRAP_W-1:0] PULLUP_MASK = 8'hFC
)(
  input wire logic CLK,
  input wire logic RST,
  input wire logic HARD_RESET_N,
  input wire logic SOFT_RESET_N,
  input wire logic TRST_N,
  input wire logic TCK_EN,
  input wire logic TMS,
  input wire logic [STRAP_W-1:0] STRAP_I,
  input wire logic [STRAP_W-1:0] FUNC_OUT,
  input wire logic [STRAP_W-1:0] FUNC_OE,
  output logic [STRAP_W-1:0] STRAP_O,
  output logic [STRAP_W-1:0] STRAP_OE,
  output logic [STRAP_W-1:0] STRAP_RX_EN,
  output logic [STRAP_W-1:0] STRAP_PULLUP_EN,
  output logic [STRAP_W-1:0] CFG_NONDEFAULT,
  output logic CFG_VALID,
  output logic MACHINE_CHECK,
  output logic TAP_IN_RESET
);
  // ---------------------------------------------------------------
  // reset phase sequencing
  // ---------------------------------------------------------------
  rsc_state_t state_q;
  rsc_state_t state_d;
  logic [`RSC_HOLD_CNT_W-1:0] hold_q;
  logic [`RSC_HOLD_CNT_W-1:0] hold_d;
  logic [STRAP_W-1:0] cfg_q;
  logic soft_q;
  logic mck_q;

  wire hard_rst = !HARD_RESET_N;
  wire release_now = (state_q == RSC_IN_RESET) && !hard_rst;
  wire hold_done = (hold_q == `RSC_HOLD_CNT_ONE);
  wire in_reset = (state_q == RSC_IN_RESET);
  wire pull_phase = (state_q != RSC_RUN);

  always_comb begin
    state_d = state_q;
    hold_d = hold_q;
    case (state_q)
      RSC_IN_RESET: begin
        if (!hard_rst) begin
          state_d = RSC_PULL_HOLD;
          hold_d = PULL_HOLD_CLKS[`RSC_HOLD_CNT_W-1:0];
        end
      end
      RSC_PULL_HOLD: begin
        hold_d = hold_q - `RSC_HOLD_CNT_ONE;
        if (hold_done) begin
          state_d = RSC_RUN;
        end
      end
      RSC_RUN: state_d = RSC_RUN;
      default: state_d = RSC_IN_RESET;
    endcase
    if (hard_rst) begin
      state_d = RSC_IN_RESET;
      hold_d = `RSC_HOLD_CNT_ZERO;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= RSC_IN_RESET;
      hold_q <= `RSC_HOLD_CNT_ZERO;
    end else begin
      state_q <= state_d;
      hold_q <= hold_d;
    end
  end

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  // stored inverted so a high (pulled-up) level means default = 0
  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_q <= `RSC_STRAP_DEFAULT;
    end else if (release_now) begin
      cfg_q <= ~STRAP_I;
    end
  end

  logic valid_q;
  always_ff @(posedge CLK) begin
    if (RST || hard_rst) begin
      valid_q <= 1'b0;
    end else if (release_now) begin
      valid_q <= 1'b1;
    end
  end

  assign CFG_NONDEFAULT = cfg_q;
  assign CFG_VALID = valid_q;

  // ---------------------------------------------------------------
  // pad control
  // ---------------------------------------------------------------
  assign STRAP_RX_EN = {STRAP_W{pull_phase}};
  assign STRAP_PULLUP_EN = {STRAP_W{pull_phase}} & PULLUP_MASK;
  assign STRAP_OE = pull_phase ? '0 : FUNC_OE;
  assign STRAP_O = FUNC_OUT;

  // ---------------------------------------------------------------
  // soft reset to machine check
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      soft_q <= 1'b0;
      mck_q <= 1'b0;
    end else begin
      soft_q <= !SOFT_RESET_N;
      mck_q <= !SOFT_RESET_N && !soft_q && !in_reset;
    end
  end
  assign MACHINE_CHECK = mck_q;

  // ---------------------------------------------------------------
  // tap controller
  // ---------------------------------------------------------------
  rsc_tap_fsm u_tap (
    .clk(CLK),
    .rst(RST),
    .tck_en(TCK_EN),
    .tms(TMS),
    .trst_n(TRST_N),
    .tap_in_reset(TAP_IN_RESET)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_rx_on_reset: assert property (@(posedge CLK) disable iff (RST)
    hard_rst |=> (STRAP_RX_EN == '1)) else $error("receiver off during hard reset");
  a_cfg_captured: assert property (@(posedge CLK) disable iff (RST)
    release_now |=> (cfg_q == ~$past(STRAP_I))) else $error("strap not captured");
  a_rx_off_after: assert property (@(posedge CLK) disable iff (RST)
    release_now ##1 (!hard_rst) [*5] |-> (STRAP_RX_EN == '0))
    else $error("receiver still on after capture");
  a_pull_hold_len: assert property (@(posedge CLK) disable iff (RST)
    release_now ##1 (!hard_rst) [*4] |-> (STRAP_PULLUP_EN == PULLUP_MASK) ##1
    (hard_rst || STRAP_PULLUP_EN == '0)) else $error("pull-up window wrong");
  a_out_only_run: assert property (@(posedge CLK) disable iff (RST)
    pull_phase |-> (STRAP_OE == '0)) else $error("strap driven during capture");
  a_soft_mck: assert property (@(posedge CLK) disable iff (RST)
    ($fell(SOFT_RESET_N) && !in_reset && !hard_rst) |=> MACHINE_CHECK ##1 !MACHINE_CHECK)
    else $error("soft reset did not raise one machine check");
  a_soft_no_rst: assert property (@(posedge CLK) disable iff (RST)
    (!SOFT_RESET_N && !hard_rst && state_q == RSC_RUN) |=> (state_q == RSC_RUN))
    else $error("soft reset reset the device");
  a_cfg_stable: assert property (@(posedge CLK) disable iff (RST)
    (valid_q && !hard_rst) |=> $stable(cfg_q)) else $error("config changed");

  c_capture: cover property (@(posedge CLK) release_now);
  c_run: cover property (@(posedge CLK) state_q == RSC_RUN);
  c_mck: cover property (@(posedge CLK) MACHINE_CHECK);
  c_tap_reset: cover property (@(posedge CLK) $rose(TAP_IN_RESET));
endmodule
`default_nettype wire

// ===== test/rsc_board_model.sv
// board side of the strap pins: resistors, driven ratio straps and pad level
`timescale 1ns/1ns
`default_nettype none
module rsc_board_model #(
  parameter int W = 8
)(
  input wire logic clk,
  input wire logic [W-1:0] pad_oe,
  input wire logic [W-1:0] pad_o,
  input wire logic [W-1:0] pull_en,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pad
);
  logic [W-1:0] last_q;

  // ---------------------------------------------
  // pad resolution
  // ---------------------------------------------
  always_ff @(posedge clk) begin
    last_q <= pad;
  end

  // an undriven pad with no pull shows a changing level, never a kept value
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (pad_oe[i]) begin
        pad[i] = pad_o[i];
      end else if (ext_en[i]) begin
        pad[i] = ext_val[i];
      end else if (pull_en[i]) begin
        pad[i] = 1'b1;
      end else begin
        pad[i] = ~last_q[i];
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/reset_strap_capture_test.sv
// self-checking bench for the reset strap capture block
`timescale 1ns/1ns
`default_nettype none
module reset_strap_capture_test;
  logic CLK, RST, HARD_RESET_N, SOFT_RESET_N, TRST_N, TCK_EN, TMS;
  logic VALID, MCK, TAPR;
  logic [7:0] FUNC_OUT, FUNC_OE, EXT_EN, EXT_VAL, PAD, SO, SOE, RX, PU, CFG;
  int num_errors, n_tests, cyc;

  rsc_strap_capture u_rsc_strap_capture (.CLK(CLK), .RST(RST), .HARD_RESET_N(HARD_RESET_N),
    .SOFT_RESET_N(SOFT_RESET_N), .TRST_N(TRST_N), .TCK_EN(TCK_EN), .TMS(TMS),
    .STRAP_I(PAD), .FUNC_OUT(FUNC_OUT), .FUNC_OE(FUNC_OE), .STRAP_O(SO), .STRAP_OE(SOE),
    .STRAP_RX_EN(RX), .STRAP_PULLUP_EN(PU), .CFG_NONDEFAULT(CFG), .CFG_VALID(VALID),
    .MACHINE_CHECK(MCK), .TAP_IN_RESET(TAPR));
  rsc_board_model u_rsc_board_model (.clk(CLK), .pad_oe(SOE), .pad_o(SO), .pull_en(PU),
    .ext_en(EXT_EN), .ext_val(EXT_VAL), .pad(PAD));

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic tick(input logic m);
    @(negedge CLK);
    TCK_EN = 1'b1;
    TMS = m;
    @(negedge CLK);
    TCK_EN = 1'b0;
  endtask

  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_capture();
    chk(RX, 8'hFF);
    chk(PU, 8'hFC);
    chk(SOE, 8'h00);
    HARD_RESET_N = 1'b1;
    @(posedge CLK);
    @(posedge CLK);
    @(negedge CLK);
    chk(CFG, 8'h0D);
    chk({7'h00, VALID}, 8'h01);
    repeat (2) @(negedge CLK);
    chk(RX, 8'hFF);
    chk(PU, 8'hFC);
    @(negedge CLK);
    chk(RX, 8'h00);
    chk(PU, 8'h00);
    chk(SOE, 8'hA5);
    chk(SO, 8'h3C);
  endtask

  task automatic t_hold();
    EXT_EN = 8'hFF;
    EXT_VAL = 8'h0C;
    repeat (10) @(negedge CLK);
    chk(CFG, 8'h0D);
  endtask

  task automatic t_soft();
    SOFT_RESET_N = 1'b0;
    @(posedge CLK);
    @(negedge CLK);
    chk({7'h00, MCK}, 8'h01);
    SOFT_RESET_N = 1'b1;
    @(negedge CLK);
    chk({7'h00, MCK}, 8'h00);
    chk({CFG[6:0], VALID}, 8'h1B);
  endtask

  task automatic t_tap();
    logic [8:0] seq;
    seq = 9'h1F2;
    TRST_N = 1'b0;
    @(negedge CLK);
    chk({7'h00, TAPR}, 8'h01);
    TRST_N = 1'b1;
    for (int i = 0; i < 8; i++) begin
      tick(seq[i]);
    end
    chk({7'h00, TAPR}, 8'h00);
    tick(1'b1);
    chk({7'h00, TAPR}, 8'h01);
  endtask

  task automatic t_rehard();
    logic probe_n;
    logic wdog_n;
    probe_n = 1'b0;
    wdog_n = 1'b1;
    // board merges probe and watchdog requests; test reset follows hard reset
    HARD_RESET_N = probe_n & wdog_n;
    TRST_N = probe_n & wdog_n;
    @(negedge CLK);
    @(negedge CLK);
    chk({7'h00, TAPR}, 8'h01);
    chk({7'h00, VALID}, 8'h00);
    chk(RX, 8'hFF);
    chk(SOE, 8'h00);
    EXT_EN = 8'h03;
    EXT_VAL = 8'h01;
    HARD_RESET_N = 1'b1;
    TRST_N = 1'b1;
    @(posedge CLK);
    @(posedge CLK);
    @(negedge CLK);
    chk(CFG, 8'h02);
  endtask

  // ---------------------------------------------
  // clock, timeout and main sequence
  // ---------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    {num_errors, n_tests, cyc} = '0;
    RST = 1'b1;
    HARD_RESET_N = 1'b0;
    SOFT_RESET_N = 1'b1;
    TRST_N = 1'b0;
    {TCK_EN, TMS} = 2'b00;
    FUNC_OUT = 8'h3C;
    FUNC_OE = 8'hA5;
    EXT_EN = 8'h0F;
    EXT_VAL = 8'h02;
    repeat (4) @(negedge CLK);
    RST = 1'b0;
    @(negedge CLK);
    TRST_N = 1'b1;
    t_capture();
    t_hold();
    t_soft();
    t_tap();
    t_rehard();
    final_report();
  end
endmodule
`default_nettype wire
